// [hw/ahsc_pkg.sv]
// How it works
// - Supply follows whichever monitored channel has the least headroom.
// - Only channels detected as in use take part in the decision.
// - Channel enable bits at registers 0x03 and 0x04, loaded from OTP, exclude channels.
// - Any active channel below the low band on an evaluation raises the supply.
// - All active channels above the high band on an evaluation, with a lower request on the feedback input, lowers it.
// - High band set through register 0x27, 0.25V to 0.6V.
// - Low band set through the same register, 0.2V to 0.55V.
// - Start setting comes from OTP and is applied before sinks turn on.
// - Dropout state goes out on the feedback pin and is shared with peers.
// - With neither raise nor lower, the setting is kept unchanged.
// - Role pin low makes a master driving feedback; high makes a reporting slave.
// - Feedback input decodes into raise, lower and hold requests.
// - Master raises supply by stepping divider code down, lowers by stepping up.
package ahsc_pkg;

  localparam int CLK_MHZ = 200;
  localparam int EVAL_PERIOD_NS = 10000;
  localparam int EVAL_CYC = (EVAL_PERIOD_NS * CLK_MHZ) / 1000;

  localparam int NUM_CH = 16;
  localparam int DIV_W = 8;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] REG_CH_EN_LO_IDX = 6'h03;
  localparam logic [5:0] REG_CH_EN_HI_IDX = 6'h04;
  localparam logic [5:0] REG_STATUS_IDX = 6'h05;
  localparam logic [5:0] REG_ACTIVE_IDX = 6'h06;
  localparam logic [5:0] REG_CTRL_IDX = 6'h07;
  localparam logic [5:0] REG_BAND_IDX = 6'h27;

  localparam logic [7:0] CH_EN_RST = 8'hFF;
  // Low band 0.45V (code 5) and high band 0.55V (code 6), 50mV steps
  localparam logic [7:0] BAND_RST = 8'h65;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam int BAND_LO_LSB = 0;
  localparam int BAND_HI_LSB = 4;
  localparam int CTRL_LOOP_EN_BIT = 0;

  localparam logic [DIV_W-1:0] DIV_MIN = 8'h08;
  localparam logic [DIV_W-1:0] DIV_MAX = 8'hF8;

  // Slave feedback output levels: 0V, 0.5V, 1V
  localparam logic [1:0] FBO_LOWER = 2'h0;
  localparam logic [1:0] FBO_HOLD = 2'h1;
  localparam logic [1:0] FBO_RAISE = 2'h2;

  typedef enum logic [1:0] {ST_LOAD, ST_SETTLE, ST_RUN} ahsc_state_e;

  function automatic logic ahsc_is_reg(input logic [7:0] addr, input logic [5:0] idx);
    return addr == {idx, 2'b00};
  endfunction : ahsc_is_reg

  function automatic logic [DIV_W-1:0] ahsc_clamp(input logic [DIV_W-1:0] code);
    if (code < DIV_MIN) begin
      return DIV_MIN;
    end
    if (code > DIV_MAX) begin
      return DIV_MAX;
    end
    return code;
  endfunction : ahsc_clamp

endpackage : ahsc_pkg

// [hw/ahsc_sync3.sv]
`timescale 1ns/1ps
module ahsc_sync3 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // A bit changes only once the second and third stages agree
  always_comb begin
    nxt_q = (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff <= '0;
    end else if (clk_en) begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;

endmodule : ahsc_sync3

// [hw/ahsc_top.sv]
`timescale 1ns/1ps
module ahsc_top
  import ahsc_pkg::*;
#(
  parameter int NCH = NUM_CH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NCH-1:0] led_below_low,
  input wire logic [NCH-1:0] led_above_high,
  input wire logic [NCH-1:0] led_in_use,
  input wire logic fbi_up_cmp,
  input wire logic fbi_down_cmp,
  input wire logic role_select_pin,
  input wire logic [15:0] otp_channel_enable_bits,
  input wire logic [DIV_W-1:0] otp_initial_div,
  output logic [2:0] band_low_code,
  output logic [2:0] band_high_code,
  output logic [DIV_W-1:0] divider_lower_resistor_code,
  output logic [1:0] feedback_out_pin_level,
  output logic sinks_enable
);

  logic [NCH-1:0] below_s;
  logic [NCH-1:0] above_s;
  logic [NCH-1:0] in_use_s;
  logic [2:0] pins_s;

  ahsc_sync3 #(.W(3 * NCH)) u_ch_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d({led_below_low, led_above_high, led_in_use}),
    .q({below_s, above_s, in_use_s})
  );

  ahsc_sync3 #(.W(3)) u_pin_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d({fbi_up_cmp, fbi_down_cmp, role_select_pin}),
    .q(pins_s)
  );

  logic up_s;
  logic down_s;
  logic slave_s;
  assign up_s = pins_s[2];
  assign down_s = pins_s[1];
  assign slave_s = pins_s[0];

  // Bus side state
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [15:0] ch_en_ff;
  logic [15:0] nxt_ch_en;
  logic [7:0] band_ff;
  logic [7:0] nxt_band;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;

  // Loop side state
  ahsc_state_e state_ff;
  ahsc_state_e nxt_state;
  localparam int CW = $clog2(EVAL_CYC);
  localparam logic [CW-1:0] CNT_LAST = CW'(EVAL_CYC - 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic [1:0] fbo_ff;
  logic [1:0] nxt_fbo;
  logic sinks_ff;
  logic nxt_sinks;
  logic raise_last_ff;
  logic nxt_raise_last;
  logic lower_last_ff;
  logic nxt_lower_last;

  logic req;
  logic [NCH-1:0] active;
  logic fbi_raise;
  logic fbi_lower;
  logic raise_req;
  logic lower_req;
  logic tick;
  logic load_otp;
  logic loop_on;
  logic [31:0] read_mux;

  assign req = avs_read | avs_write;
  // One wait cycle; a frozen clock enable keeps the master waiting
  assign avs_waitrequest = req & ~(ack_ff & clk_en);
  assign avs_readdata = rdata_ff;
  assign load_otp = (state_ff == ST_LOAD);
  assign loop_on = ctrl_ff[CTRL_LOOP_EN_BIT];

  assign active = ch_en_ff[NCH-1:0] & in_use_s;

  // three-way feedback decode, contradiction counts as hold
  assign fbi_raise = up_s & ~down_s;
  assign fbi_lower = down_s & ~up_s;

  assign raise_req = (|(active & below_s)) | fbi_raise;
  assign lower_req = (&(~active | above_s)) & fbi_lower & ~raise_req;

  assign tick = (cnt_ff == CNT_LAST);

  always_comb begin
    read_mux = 32'h0000_0000;
    if (ahsc_is_reg(avs_address, REG_CH_EN_LO_IDX)) begin
      read_mux = {24'h00_0000, ch_en_ff[7:0]};
    end else if (ahsc_is_reg(avs_address, REG_CH_EN_HI_IDX)) begin
      read_mux = {24'h00_0000, ch_en_ff[15:8]};
    end else if (ahsc_is_reg(avs_address, REG_BAND_IDX)) begin
      read_mux = {24'h00_0000, band_ff};
    end else if (ahsc_is_reg(avs_address, REG_CTRL_IDX)) begin
      read_mux = {24'h00_0000, ctrl_ff};
    end else if (ahsc_is_reg(avs_address, REG_STATUS_IDX)) begin
      read_mux = {20'h0_0000, sinks_ff, slave_s, lower_last_ff, raise_last_ff, div_ff};
    end else if (ahsc_is_reg(avs_address, REG_ACTIVE_IDX)) begin
      read_mux = {16'h0000, active};
    end
  end

  always_comb begin
    nxt_ack = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_ch_en = ch_en_ff;
    nxt_band = band_ff;
    nxt_ctrl = ctrl_ff;
    if (load_otp) begin
      nxt_ch_en = otp_channel_enable_bits;
    end
    if (req && !ack_ff) begin
      nxt_ack = 1'b1;
      nxt_rdata = read_mux;
    end
    if (avs_write && ack_ff && avs_byteenable[0]) begin
      if (ahsc_is_reg(avs_address, REG_CH_EN_LO_IDX)) begin
        nxt_ch_en[7:0] = avs_writedata[7:0];
      end
      if (ahsc_is_reg(avs_address, REG_CH_EN_HI_IDX)) begin
        nxt_ch_en[15:8] = avs_writedata[7:0];
      end
      if (ahsc_is_reg(avs_address, REG_BAND_IDX)) begin
        nxt_band = {1'b0, avs_writedata[6:4], 1'b0, avs_writedata[2:0]};
      end
      if (ahsc_is_reg(avs_address, REG_CTRL_IDX)) begin
        nxt_ctrl = {7'h00, avs_writedata[0]};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      ch_en_ff <= {CH_EN_RST, CH_EN_RST};
      band_ff <= BAND_RST;
      ctrl_ff <= CTRL_RST;
    end else if (clk_en) begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      ch_en_ff <= nxt_ch_en;
      band_ff <= nxt_band;
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = tick ? '0 : cnt_ff + 1'b1;
    nxt_div = div_ff;
    nxt_fbo = fbo_ff;
    nxt_sinks = sinks_ff;
    nxt_raise_last = raise_last_ff;
    nxt_lower_last = lower_last_ff;
    case (state_ff)
      ST_LOAD: begin
        // OTP start setting, sinks held off
        nxt_div = ahsc_clamp(otp_initial_div);
        nxt_cnt = '0;
        nxt_sinks = 1'b0;
        nxt_state = ST_SETTLE;
      end
      ST_SETTLE: begin
        // one period for the supply to settle before sinks run
        if (tick) begin
          nxt_sinks = 1'b1;
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tick) begin
          nxt_raise_last = raise_req;
          nxt_lower_last = lower_req;
          if (!loop_on) begin
            nxt_fbo = FBO_HOLD;
          end else if (slave_s) begin
            // dropout state onto the feedback pin
            nxt_fbo = raise_req ? FBO_RAISE : (lower_req ? FBO_LOWER : FBO_HOLD);
          end else begin
            nxt_fbo = FBO_HOLD;
            // raise steps the divider down, lower steps it up
            if (raise_req && div_ff > DIV_MIN) begin
              nxt_div = div_ff - 1'b1;
            end else if (lower_req && div_ff < DIV_MAX) begin
              nxt_div = div_ff + 1'b1;
            end
          end
        end
      end
      default: begin
        nxt_state = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= ST_LOAD;
      cnt_ff <= '0;
      div_ff <= DIV_MAX;
      fbo_ff <= FBO_HOLD;
      sinks_ff <= 1'b0;
      raise_last_ff <= 1'b0;
      lower_last_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
      fbo_ff <= nxt_fbo;
      sinks_ff <= nxt_sinks;
      raise_last_ff <= nxt_raise_last;
      lower_last_ff <= nxt_lower_last;
    end
  end

  // band codes drive the comparator references
  assign band_low_code = band_ff[BAND_LO_LSB +: 3];
  assign band_high_code = band_ff[BAND_HI_LSB +: 3];
  assign divider_lower_resistor_code = div_ff;
  assign feedback_out_pin_level = fbo_ff;
  assign sinks_enable = sinks_ff;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence eval_s;
    clk_en && tick && state_ff == ST_RUN && loop_on;
  endsequence

  sequence master_raise_s;
    eval_s ##0 (!slave_s && raise_req && div_ff > DIV_MIN);
  endsequence

  sequence master_lower_s;
    eval_s ##0 (!slave_s && lower_req && div_ff < DIV_MAX);
  endsequence

  div_range_a: assert property (div_ff >= DIV_MIN && div_ff <= DIV_MAX)
    else $error("divider code left its window");

  raise_step_a: assert property (master_raise_s |=> div_ff == $past(div_ff) - 8'h01)
    else $error("raise did not step divider down");

  lower_step_a: assert property (master_lower_s |=> div_ff == $past(div_ff) + 8'h01)
    else $error("lower did not step divider up");

  hold_code_a: assert property (eval_s ##0 (!raise_req && !lower_req) |=> $stable(div_ff))
    else $error("divider moved without a request");

  weak_chan_a: assert property (eval_s ##0 (|(active & below_s)) ##0 !slave_s && div_ff > DIV_MIN
    |=> div_ff < $past(div_ff))
    else $error("low headroom did not raise supply");

  slave_report_a: assert property (eval_s ##0 (slave_s && raise_req) |=> fbo_ff == FBO_RAISE)
    else $error("slave did not report raise");

  master_quiet_a: assert property (eval_s ##0 !slave_s |=> fbo_ff == FBO_HOLD)
    else $error("master drove a report level");

  mask_gate_a: assert property ((active & ~ch_en_ff[NCH-1:0]) == '0)
    else $error("disabled channel counted as active");

  fbi_decode_a: assert property (up_s && down_s |-> !fbi_raise && !fbi_lower)
    else $error("contradictory feedback not held");

  band_write_a: assert property (avs_write && ack_ff && clk_en && avs_byteenable[0]
    && ahsc_is_reg(avs_address, REG_BAND_IDX)
    |=> band_low_code == $past(avs_writedata[2:0]) && band_high_code == $past(avs_writedata[6:4]))
    else $error("band write not applied");

  init_load_a: assert property (clk_en && state_ff == ST_LOAD
    |=> div_ff == ahsc_clamp($past(otp_initial_div)) && !sinks_enable)
    else $error("start setting not loaded before sinks");

  sink_order_a: assert property (sinks_enable |-> state_ff == ST_RUN)
    else $error("sinks on before run");

endmodule : ahsc_top

// [sim/ahsc_peer_model.sv]
`timescale 1ns/1ps
module ahsc_peer_model
  import ahsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic peer_present,
  input wire logic [1:0] peer_level,
  output logic fbi_up_cmp,
  output logic fbi_down_cmp
);
  // Board without a peer grounds the input, which reads as a lower request
  initial begin
    fbi_up_cmp = 1'b0;
    fbi_down_cmp = 1'b1;
  end
  always @(posedge clk_sys) begin
    fbi_up_cmp <= peer_present && peer_level == FBO_RAISE;
    fbi_down_cmp <= !peer_present || peer_level == FBO_LOWER;
  end
endmodule : ahsc_peer_model

// [sim/adaptive_headroom_supply_control_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module adaptive_headroom_supply_control_tb
  import ahsc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] below = 16'h0;
  logic [15:0] above = 16'h0;
  logic [15:0] in_use = 16'h00FF;
  logic [15:0] otp_en = 16'hFF7F;
  logic role = 1'b0;
  logic peer_present = 1'b0;
  logic [1:0] peer_level = FBO_HOLD;
  logic [7:0] otp_div = 8'hFF;
  logic fbi_up;
  logic fbi_down;
  logic [2:0] band_lo;
  logic [2:0] band_hi;
  logic [7:0] div;
  logic [1:0] feedback_out_pin;
  logic sinks;
  logic [31:0] rd;
  logic [7:0] bands [3] = '{8'h00, 8'hFF, 8'h32};
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2.5 clk_sys = ~clk_sys;

  ahsc_top u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .led_below_low(below), .led_above_high(above), .led_in_use(in_use),
    .fbi_up_cmp(fbi_up), .fbi_down_cmp(fbi_down), .role_select_pin(role),
    .otp_channel_enable_bits(otp_en), .otp_initial_div(otp_div),
    .band_low_code(band_lo), .band_high_code(band_hi),
    .divider_lower_resistor_code(div), .feedback_out_pin_level(feedback_out_pin), .sinks_enable(sinks)
  );

  ahsc_peer_model u_peer (
    .clk_sys(clk_sys), .peer_present(peer_present), .peer_level(peer_level),
    .fbi_up_cmp(fbi_up), .fbi_down_cmp(fbi_down)
  );

  task automatic complete_run();
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Three resets with settle plus about fourteen evaluation periods, with margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 50000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // Request stands until waitrequest is sampled low at a rising edge; data is taken at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic drive(input logic [15:0] b, input logic [15:0] a, input logic pp, input logic [1:0] pl);
    @(posedge clk_sys);
    below <= b;
    above <= a;
    peer_present <= pp;
    peer_level <= pl;
  endtask : drive

  // A hold case runs the whole window, which spans one evaluation unless clk_en is held low
  task automatic step(input logic [7:0] e_div, input logic [1:0] e_fbo);
    logic [7:0] d0;
    logic [1:0] f0;
    int i;
    d0 = div;
    f0 = feedback_out_pin;
    for (i = 0; i < 2100; i++) begin
      @(negedge clk_sys);
      if (div !== d0 || feedback_out_pin !== f0) break;
    end
    `CHK("divider_code", e_div, div)
    `CHK("feedback_out", e_fbo, feedback_out_pin)
  endtask : step

  task automatic do_reset(input logic [7:0] od, input logic r);
    logic [7:0] e;
    int i;
    e = od < DIV_MIN ? DIV_MIN : (od > DIV_MAX ? DIV_MAX : od);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    otp_div <= od;
    role <= r;
    below <= 16'h0;
    above <= 16'h0;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("start_divider", e, div)
    `CHK("sinks_early", 1'b0, sinks)
    for (i = 0; i < 2100; i++) begin
      @(negedge clk_sys);
      if (sinks === 1'b1) break;
    end
    `CHK("sinks_on", 1'b1, sinks)
    $display("test reset done");
  endtask : do_reset

  initial begin
    do_reset(8'hFF, 1'b0);
    bus(1'b0, 8'h0C, 8'h00);
    `CHK("ch_enable_lo", 32'h7F, rd)
    bus(1'b0, 8'h10, 8'h00);
    `CHK("ch_enable_hi", 32'hFF, rd)
    bus(1'b0, 8'h1C, 8'h00);
    `CHK("ctrl", {24'h0, CTRL_RST}, rd)
    bus(1'b0, 8'h18, 8'h00);
    `CHK("active_mask", 32'h7F, rd)
    bus(1'b0, 8'h14, 8'h00);
    `CHK("status", 32'h8F8, rd)
    bus(1'b0, 8'h9C, 8'h00);
    `CHK("band_reset", {24'h0, BAND_RST}, rd)
    bus(1'b1, 8'h40, 8'hAA);
    bus(1'b0, 8'h40, 8'h00);
    `CHK("unmapped", 32'h0, rd)
    foreach (bands[k]) begin
      bus(1'b1, 8'h9C, bands[k]);
      bus(1'b0, 8'h9C, 8'h00);
      `CHK("band_read", {24'h0, bands[k] & 8'h77}, rd)
      `CHK("band_low", bands[k][2:0], band_lo)
      `CHK("band_high", bands[k][6:4], band_hi)
    end
    $display("test registers done");
    drive(16'h0, 16'h00FF, 1'b0, FBO_HOLD);
    step(8'hF8, FBO_HOLD);
    drive(16'h0001, 16'h0, 1'b0, FBO_HOLD);
    step(8'hF7, FBO_HOLD);
    drive(16'h0180, 16'h0, 1'b0, FBO_HOLD);
    step(8'hF7, FBO_HOLD);
    drive(16'h0, 16'h007F, 1'b0, FBO_HOLD);
    step(8'hF8, FBO_HOLD);
    drive(16'h0, 16'h003F, 1'b0, FBO_HOLD);
    step(8'hF8, FBO_HOLD);
    drive(16'h0, 16'h007F, 1'b1, FBO_RAISE);
    step(8'hF7, FBO_HOLD);
    drive(16'h0, 16'h007F, 1'b1, FBO_HOLD);
    step(8'hF7, FBO_HOLD);
    $display("test master loop done");
    @(posedge clk_sys);
    clk_en <= 1'b0;
    drive(16'h0001, 16'h0, 1'b0, FBO_HOLD);
    step(8'hF7, FBO_HOLD);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    step(8'hF6, FBO_HOLD);
    bus(1'b1, 8'h1C, 8'h00);
    step(8'hF6, FBO_HOLD);
    $display("test freeze and loop off done");
    do_reset(8'h07, 1'b0);
    drive(16'h0001, 16'h0, 1'b0, FBO_HOLD);
    step(8'h08, FBO_HOLD);
    $display("test saturation done");
    do_reset(8'h80, 1'b1);
    drive(16'h0001, 16'h0, 1'b0, FBO_HOLD);
    step(8'h80, FBO_RAISE);
    drive(16'h0, 16'h007F, 1'b0, FBO_HOLD);
    step(8'h80, FBO_LOWER);
    drive(16'h0, 16'h003F, 1'b0, FBO_HOLD);
    step(8'h80, FBO_HOLD);
    $display("test slave loop done");
    complete_run();
  end
endmodule : adaptive_headroom_supply_control_tb
